/* rtl/ffb_pkg.sv */
// Register map and field layout of the fault status flag bank
package ffb_pkg;
    // Printed offset 0x12 is not a multiple of four: offsets kept as indices
    localparam logic [7:0] FFB_BOOST_IDX = 8'h10;
    localparam logic [7:0] FFB_LED_IDX = 8'h12;
    localparam logic [7:0] FFB_INTEN_IDX = 8'h20;
    localparam logic [11:0] FFB_BOOST_ADDR = {2'h0, FFB_BOOST_IDX, 2'h0};
    localparam logic [11:0] FFB_LED_ADDR = {2'h0, FFB_LED_IDX, 2'h0};
    localparam logic [11:0] FFB_INTEN_ADDR = {2'h0, FFB_INTEN_IDX, 2'h0};
    localparam int FFB_ADDR_W = 12;

    // Boost register flag positions; clear bit sits one below each flag
    localparam int FFB_BOOST_NFLAG = 8;
    localparam int FFB_OVERHEAT_BIT = 15;
    localparam int FFB_ISHORT_BIT = 13;
    localparam int FFB_STRRES_BIT = 11;
    localparam int FFB_MODERES_BIT = 9;
    localparam int FFB_FREQRES_BIT = 7;
    localparam int FFB_OCP_BIT = 5;
    localparam int FFB_OVPH_BIT = 3;
    localparam int FFB_OVPL_BIT = 1;

    // LED register fields
    localparam int FFB_TIMEOUT_BIT = 14;
    localparam int FFB_BADCFG_BIT = 12;
    localparam int FFB_SUMMARY_BIT = 10;
    localparam int FFB_GND_BIT = 8;
    localparam int FFB_SHORT_BIT = 7;
    localparam int FFB_OPEN_BIT = 6;
    localparam int FFB_NCHAN = 4;

    // Interrupt enable fields, two bits each, in the enable register
    localparam int FFB_NEN = 4;
    localparam logic [1:0] FFB_EN_READ_ON = 2'h2;
    localparam logic [1:0] FFB_EN_READ_OFF = 2'h0;
    localparam logic [1:0] FFB_EN_WR_ON = 2'h3;
    localparam logic [1:0] FFB_EN_WR_OFF = 2'h1;
    localparam logic [3:0] FFB_EN_RESET = 4'hF;

    localparam logic [15:0] FFB_BOOST_RESET = 16'h0000;
    localparam logic [15:0] FFB_LED_RESET = 16'h0000;
endpackage : ffb_pkg

/* rtl/ffb_fault_bank.sv */
// Fault status flag bank with APB register access and interrupt pin
//
// Functional notes
// RQ1 - Flag clears only when flag bit and its clear bit both written 1.
// RQ2 - Overheat flag at boost bit 15, clear at bit 14.
// RQ3 - Current resistor short flag at boost bit 13, clear bit 12.
// RQ4 - Missing string resistor flag at boost bit 11, clear bit 10.
// RQ5 - Missing mode resistor flag at boost bit 9, clear bit 8.
// RQ6 - Missing frequency resistor flag at boost bit 7, clear bit 6.
// RQ7 - Boost overcurrent flag at boost bit 5, clear bit 4.
// RQ8 - Boost overvoltage high flag at boost bit 3, clear bit 2.
// RQ9 - Boost overvoltage low flag at bit 1; clear bit 0 clears flag. Code clears it only when bits 1 and 0 are both written 1.
// RQ10 - Bus timeout flag at LED bit 14, clear bit 13.
// RQ11 - Bad string configuration flag at LED bit 12, clear bit 11.
// RQ12 - Summary string fault flag at LED bit 10, clear bit 9.
// RQ13 - Grounded string detail, read-only LED bit 8.
// RQ14 - Shorted string detail, read-only bit 7, cleared with summary.
// RQ15 - Open string detail, read-only bit 6, cleared with summary.
// RQ16 - Host writes zero to reserved LED bits 5 and 4.
// RQ17 - Per-channel fault bits 3..0, channel four at bit 3.
// RQ18 - LED register bit 15 reserved.
// RQ19 - Enable fields read 2 on, 0 off; write 3 enables, 1 disables.
// RQ20 - Flags stay latched; partial writes leave them unchanged.
// RQ21 - Interrupt active while any enabled latched flag is set.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module ffb_fault_bank (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ffb_pkg::FFB_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [ffb_pkg::FFB_BOOST_NFLAG-1:0] boost_fault_i,
    input wire logic bus_timeout_i,
    input wire logic bad_string_cfg_i,
    input wire logic string_grounded_i,
    input wire logic string_shorted_i,
    input wire logic string_open_i,
    input wire logic [ffb_pkg::FFB_NCHAN-1:0] channel_fault_i,
    output logic irq_o
);
    import ffb_pkg::*;

    typedef struct packed {
        logic [FFB_BOOST_NFLAG-1:0] boost_flags;
        logic timeout_flag;
        logic badcfg_flag;
        logic summary_flag;
        logic grounded;
        logic shorted;
        logic opened;
        logic [FFB_NCHAN-1:0] chan;
        logic [FFB_NEN-1:0] en;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } ffb_state_t;

    ffb_state_t state_q;
    ffb_state_t state_d;

    logic [15:0] boost_view;
    logic [15:0] led_view;
    logic [7:0] en_view_c;
    logic [15:0] wlo;
    logic wr_lo;
    logic setup;
    logic hit_boost;
    logic hit_led;
    logic hit_en;
    logic [FFB_BOOST_NFLAG-1:0] boost_clr;
    logic [FFB_BOOST_NFLAG-1:0] boost_next;

    // Boost flags are on odd bits, clear bits one below
    genvar gi;
    generate
        for (gi = 0; gi < FFB_BOOST_NFLAG; gi++) begin : g_boost
            assign boost_view[2*gi+1] = state_q.boost_flags[gi];
            assign boost_view[2*gi] = 1'b0;
            // Clear needs flag and clear bit written 1 together [RQ1] [RQ20]
            assign boost_clr[gi] = wr_lo && hit_boost && wlo[2*gi+1] && wlo[2*gi];
            // Set wins over a clear in the same cycle [RQ2] [RQ3] [RQ4] [RQ5]
            // [RQ6] [RQ7] [RQ8] [RQ9]
            assign boost_next[gi] = boost_fault_i[gi] || (state_q.boost_flags[gi] && !boost_clr[gi]);
        end
    endgenerate

    always_comb begin
        led_view = 16'h0000;
        led_view[15] = 1'b0; // [RQ18]
        led_view[FFB_TIMEOUT_BIT] = state_q.timeout_flag; // [RQ10]
        led_view[FFB_BADCFG_BIT] = state_q.badcfg_flag; // [RQ11]
        led_view[FFB_SUMMARY_BIT] = state_q.summary_flag; // [RQ12]
        led_view[FFB_GND_BIT] = state_q.grounded; // [RQ13]
        led_view[FFB_SHORT_BIT] = state_q.shorted; // [RQ14]
        led_view[FFB_OPEN_BIT] = state_q.opened; // [RQ15]
        led_view[FFB_NCHAN-1:0] = state_q.chan; // [RQ17]
    end

    always_comb begin
        for (int i = 0; i < FFB_NEN; i++) begin
            en_view_c[2*i +: 2] = state_q.en[i] ? FFB_EN_READ_ON : FFB_EN_READ_OFF; // [RQ19]
        end
    end

    assign setup = psel_i && !penable_i;
    assign wlo = pwdata_i[15:0];
    assign wr_lo = setup && pwrite_i && pstrb_i[0] && pstrb_i[1];
    assign hit_boost = paddr_i == FFB_BOOST_ADDR;
    assign hit_led = paddr_i == FFB_LED_ADDR;
    assign hit_en = paddr_i == FFB_INTEN_ADDR;

    always_comb begin
        logic clr_to;
        logic clr_bc;
        logic clr_sum;
        logic any_led;
        clr_to = 1'b0;
        clr_bc = 1'b0;
        clr_sum = 1'b0;
        any_led = 1'b0;
        state_d = state_q;
        state_d.boost_flags = boost_next;
        if (wr_lo && hit_led) begin
            // Bits 5 and 4 ignored; host keeps them zero [RQ16]
            clr_to = wlo[FFB_TIMEOUT_BIT] && wlo[FFB_TIMEOUT_BIT-1]; // [RQ1]
            clr_bc = wlo[FFB_BADCFG_BIT] && wlo[FFB_BADCFG_BIT-1]; // [RQ1]
            clr_sum = wlo[FFB_SUMMARY_BIT] && wlo[FFB_SUMMARY_BIT-1]; // [RQ1]
        end
        state_d.timeout_flag = bus_timeout_i || (state_q.timeout_flag && !clr_to); // [RQ10]
        state_d.badcfg_flag = bad_string_cfg_i || (state_q.badcfg_flag && !clr_bc); // [RQ11]
        any_led = string_grounded_i || string_shorted_i || string_open_i;
        state_d.summary_flag = any_led || (state_q.summary_flag && !clr_sum); // [RQ12] [RQ20]
        state_d.grounded = string_grounded_i || (state_q.grounded && !clr_sum); // [RQ13]
        state_d.shorted = string_shorted_i || (state_q.shorted && !clr_sum); // [RQ14]
        state_d.opened = string_open_i || (state_q.opened && !clr_sum); // [RQ15]
        state_d.chan = channel_fault_i; // [RQ17]
        if (setup && pwrite_i && pstrb_i[0] && hit_en) begin
            for (int i = 0; i < FFB_NEN; i++) begin
                if (pwdata_i[2*i +: 2] == FFB_EN_WR_ON) begin
                    state_d.en[i] = 1'b1; // [RQ19]
                end else if (pwdata_i[2*i +: 2] == FFB_EN_WR_OFF) begin
                    state_d.en[i] = 1'b0; // [RQ19]
                end
            end
        end
        // Enable 0 gates boost, 1 timeout, 2 bad config, 3 string faults
        state_d.irq = (state_d.en[0] && (|state_d.boost_flags))
            || (state_d.en[1] && state_d.timeout_flag)
            || (state_d.en[2] && state_d.badcfg_flag)
            || (state_d.en[3] && state_d.summary_flag); // [RQ21] [RQ1]
        // No wait state: answer in first access-phase cycle
        state_d.ready = setup;
        state_d.slverr = setup && !(hit_boost || hit_led || hit_en);
        state_d.rdata = 32'h0000_0000;
        if (setup && !pwrite_i) begin
            if (hit_boost) begin
                state_d.rdata = {16'h0000, boost_view};
            end else if (hit_led) begin
                state_d.rdata = {16'h0000, led_view};
            end else if (hit_en) begin
                state_d.rdata = {24'h00_0000, en_view_c};
            end
        end
        if (srst_i) begin
            state_d = '0;
            state_d.boost_flags = FFB_BOOST_RESET[FFB_BOOST_NFLAG-1:0];
            state_d.en = FFB_EN_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        state_q <= state_d;
    end

    assign prdata_o = state_q.rdata;
    assign pready_o = state_q.ready;
    assign pslverr_o = state_q.slverr;
    assign irq_o = state_q.irq;
endmodule : ffb_fault_bank

`default_nettype wire

/* tb/ffb_fault_bank_props.sv */
// Assertions on the ports of the fault status flag bank
`timescale 1ns/1ps
`default_nettype none
module ffb_fault_bank_props (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ffb_pkg::FFB_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [ffb_pkg::FFB_BOOST_NFLAG-1:0] boost_fault_i,
    input wire logic [ffb_pkg::FFB_NCHAN-1:0] channel_fault_i,
    input wire logic irq_o
);
    import ffb_pkg::*;
    logic setup_w, map_w, rd_boost_w, rd_led_w;
    assign setup_w = psel_i && !penable_i;
    assign map_w = paddr_i == FFB_BOOST_ADDR || paddr_i == FFB_LED_ADDR || paddr_i == FFB_INTEN_ADDR;
    assign rd_boost_w = setup_w && !pwrite_i && paddr_i == FFB_BOOST_ADDR;
    assign rd_led_w = setup_w && !pwrite_i && paddr_i == FFB_LED_ADDR;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    AST_READY_AFTER_SETUP: assert property (setup_w |=> pready_o)
        else $error("no ready after setup");
    AST_READY_ONLY_ACCESS: assert property (pready_o |-> $past(setup_w))
        else $error("stray ready");
    AST_ERR_UNMAPPED: assert property (setup_w && !map_w |=> pready_o && pslverr_o)
        else $error("unmapped not refused");
    AST_ERR_MAPPED: assert property (setup_w && map_w |=> !pslverr_o)
        else $error("mapped refused");
    AST_IRQ_ON_BOOST: assert property (boost_fault_i != 8'h00 |=> irq_o)
        else $error("irq not raised");
    AST_BOOST_LATCH: assert property (rd_boost_w && $past(boost_fault_i[7]) && !$past(srst_i)
        |=> prdata_o[FFB_OVERHEAT_BIT])
        else $error("overheat not latched");
    AST_CHAN_LIVE: assert property (rd_led_w |=> prdata_o[3:0] == $past(channel_fault_i, 2))
        else $error("channel bits wrong");
    AST_LED_RSVD_ZERO: assert property (rd_led_w |=> (prdata_o & 32'hFFFF_AA30) == 32'h0)
        else $error("led reserved bits set");
    AST_BOOST_CLR_ZERO: assert property (rd_boost_w |=> (prdata_o & 32'hFFFF_5555) == 32'h0)
        else $error("boost clear bits set");
    cover property (pslverr_o);
    cover property ($fell(irq_o));
    cover property (setup_w && pwrite_i && paddr_i == FFB_LED_ADDR);
endmodule : ffb_fault_bank_props
bind ffb_fault_bank ffb_fault_bank_props u_props (.clk_i(clk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .boost_fault_i(boost_fault_i), .channel_fault_i(channel_fault_i), .irq_o(irq_o));
`default_nettype wire

/* tb/test_fault_status_flag_bank.sv */
// Directed register test of the fault status flag bank
`timescale 1ns/1ps
`default_nettype none
module test_fault_status_flag_bank;
    import ffb_pkg::*;
    logic clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, q;
    logic [3:0] pstrb_i = 4'hF, channel_fault_i = '0;
    logic [7:0] boost_fault_i = '0;
    logic bus_timeout_i = 0, bad_string_cfg_i = 0, string_grounded_i = 0;
    logic string_shorted_i = 0, string_open_i = 0, pready_o, pslverr_o, irq_o, e;
    int bad_count = 0, total_checks = 0, cyc = 0;
    ffb_fault_bank dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .boost_fault_i(boost_fault_i), .bus_timeout_i(bus_timeout_i),
        .bad_string_cfg_i(bad_string_cfg_i), .string_grounded_i(string_grounded_i),
        .string_shorted_i(string_shorted_i), .string_open_i(string_open_i),
        .channel_fault_i(channel_fault_i), .irq_o(irq_o));
    initial forever #10 clk_i = ~clk_i;
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
        @(posedge clk_i);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 32'h0);
        chk(q, x);
        chk({31'h0, e}, 32'h0);
    endtask : rd
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 0;
        rd(FFB_BOOST_ADDR, 32'h0);
        rd(FFB_LED_ADDR, 32'h0);
        rd(FFB_INTEN_ADDR, 32'hAA);
        for (int k = 0; k < 8; k++) begin
            boost_fault_i <= 8'h01 << k;
            @(posedge clk_i);
            boost_fault_i <= 8'h00;
            rd(FFB_BOOST_ADDR, 32'h2 << 2 * k);
            chk({31'h0, irq_o}, 32'h1);
            wr(FFB_BOOST_ADDR, 32'h2 << 2 * k);
            wr(FFB_BOOST_ADDR, 32'h1 << 2 * k);
            rd(FFB_BOOST_ADDR, 32'h2 << 2 * k);
            wr(FFB_BOOST_ADDR, 32'h3 << 2 * k);
            rd(FFB_BOOST_ADDR, 32'h0);
            chk({31'h0, irq_o}, 32'h0);
        end
        for (int i = 0; i < 2; i++) begin
            bus_timeout_i <= (i == 0);
            bad_string_cfg_i <= (i == 1);
            @(posedge clk_i);
            bus_timeout_i <= 0;
            bad_string_cfg_i <= 0;
            rd(FFB_LED_ADDR, 32'h4000 >> 2 * i);
            wr(FFB_LED_ADDR, 32'h6000 >> 2 * i);
            rd(FFB_LED_ADDR, 32'h0);
        end
        channel_fault_i <= 4'h9;
        {string_grounded_i, string_shorted_i, string_open_i} <= 3'h7;
        @(posedge clk_i);
        {string_grounded_i, string_shorted_i, string_open_i} <= 3'h0;
        rd(FFB_LED_ADDR, 32'h05C9);
        wr(FFB_LED_ADDR, 32'h0600);
        rd(FFB_LED_ADDR, 32'h0009);
        channel_fault_i <= 4'h6;
        @(posedge clk_i);
        rd(FFB_LED_ADDR, 32'h0006);
        wr(FFB_INTEN_ADDR, 32'h55);
        rd(FFB_INTEN_ADDR, 32'h0);
        bus_timeout_i <= 1;
        @(posedge clk_i);
        bus_timeout_i <= 0;
        rd(FFB_LED_ADDR, 32'h4006);
        chk({31'h0, irq_o}, 32'h0);
        wr(FFB_INTEN_ADDR, 32'h0C);
        rd(FFB_INTEN_ADDR, 32'h08);
        chk({31'h0, irq_o}, 32'h1);
        wr(FFB_LED_ADDR, 32'h6000);
        wr(FFB_INTEN_ADDR, 32'hFF);
        rd(FFB_INTEN_ADDR, 32'hAA);
        apb(0, 12'h044, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        give_verdict();
    end
endmodule : test_fault_status_flag_bank
`default_nettype wire
